// ### rtl/dcf_pkg.sv
// Purpose: Shared constants and carriers for the debug counter freeze bank
// Assumes: 32-bit word register port, 8-bit byte address
// Notes:   Reserved-bit masks are literal constants that match the field positions
package dcf_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned GATE_N = 9;

    // Register byte offsets
    localparam logic [7:0] OFS_FREEZE_ONE = 8'h08;
    localparam logic [7:0] OFS_FREEZE_TWO = 8'h0c;

    // Power-on values
    localparam logic [31:0] RST_FREEZE_ONE = 32'h0000_0000;
    localparam logic [31:0] RST_FREEZE_TWO = 32'h0000_0000;
    localparam logic [31:0] RST_READ_DATA  = 32'h0000_0000;

    // First register field positions
    localparam int unsigned POS_LOW_POWER_TIMER = 31;
    localparam int unsigned POS_INDEP_WATCHDOG  = 12;
    localparam int unsigned POS_WINDOW_WATCHDOG = 11;
    localparam int unsigned POS_CALENDAR_CLOCK  = 10;
    localparam int unsigned POS_TIMER_3         = 1;

    // Second register field positions
    localparam int unsigned POS_TIMER_17        = 18;
    localparam int unsigned POS_TIMER_16        = 17;
    localparam int unsigned POS_TIMER_14        = 15;
    localparam int unsigned POS_ADVANCED_TIMER  = 11;

    // Implemented bits; everything else is reserved
    localparam logic [31:0] MASK_FREEZE_ONE = 32'h8000_1c02;
    localparam logic [31:0] MASK_FREEZE_TWO = 32'h0006_8800;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wrData;
        logic        wrStb;
        logic        rdStb;
    } dcf_req_t;

    // One means the counter clock is running
    typedef struct packed {
        logic lowPowerTimer;
        logic independentWatchdog;
        logic windowWatchdog;
        logic calendarClock;
        logic generalTimerThree;
        logic generalTimerSeventeen;
        logic generalTimerSixteen;
        logic generalTimerFourteen;
        logic advancedTimerOne;
    } dcf_gate_t;

    typedef struct packed {
        logic [31:0] haltFreezeControlOne;
        logic [31:0] haltFreezeControlTwo;
        logic [31:0] readData;
    } dcf_state_t;

    localparam dcf_state_t RST_STATE = '{
        haltFreezeControlOne: RST_FREEZE_ONE,
        haltFreezeControlTwo: RST_FREEZE_TWO,
        readData:             RST_READ_DATA
    };

endpackage

// ### rtl/dcf_freeze_bank.sv
// Purpose: Debug freeze bank gating peripheral counter clocks during core halt
// Assumes: Master never waits; reads answer one cycle after the strobe
// Notes:   Power-on reset is the only reset that clears the freeze bits
//
// Summary of operation
// (R1) Power-on reset clears both freeze registers asynchronously; system reset does not.
// (R2) Writes to the freeze registers land even while system reset is low.
// (R3) Every freeze bit reads zero after power-on, so counters run by default.
// (R4) Register one bit 31 freezes the low-power timer clock during halt.
// (R5) Register one bit 12 freezes the independent watchdog clock during halt.
// (R6) Register one bit 11 freezes the window watchdog clock during halt.
// (R7) Register one bit 10 freezes the calendar clock counter during halt.
// (R8) Register one bit 1 freezes general timer three during halt.
// (R9) Register two bit 18 freezes general timer seventeen during halt.
// (R10) Register two bit 17 freezes general timer sixteen during halt.
// (R11) Register two bit 15 freezes general timer fourteen during halt.
// (R12) Register two bit 11 freezes advanced timer one during halt.
// (R13) Software uses only full 32-bit word accesses to register two.
// (R14) Reserved bits read zero and ignore writes.
// (R15) A gate closes only while halted with its bit set; reopens when halt ends.
//
// Our own choice: strobed register access.
module dcf_freeze_bank
    import dcf_pkg::*;
(
    // Clock and resets
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        porRst_b,
    // Register port
    input  wire dcf_req_t    busReq,
    output logic      [31:0] rdData,
    // Core side
    input  wire logic        coreHalted,
    // Counter clock gates
    output dcf_gate_t        clkEnable
);

    dcf_state_t st_r;
    dcf_state_t st_nxt;
    logic [GATE_N-1:0] freezeVec;
    logic [GATE_N-1:0] enableVec;

    // The bus has no byte lanes, so every write is a whole word [R13]
    always_comb begin
        st_nxt = st_r;
        // No reset term here: a debugger can set bits under system reset [R2]
        if (busReq.wrStb && busReq.addr == OFS_FREEZE_ONE) begin
            st_nxt.haltFreezeControlOne = busReq.wrData & MASK_FREEZE_ONE; // [R14]
        end
        if (busReq.wrStb && busReq.addr == OFS_FREEZE_TWO) begin
            st_nxt.haltFreezeControlTwo = busReq.wrData & MASK_FREEZE_TWO; // [R14]
        end
        st_nxt.readData = RST_READ_DATA;
        if (busReq.rdStb) begin
            case (busReq.addr)
                OFS_FREEZE_ONE: begin
                    st_nxt.readData = st_r.haltFreezeControlOne & MASK_FREEZE_ONE; // [R14]
                end
                OFS_FREEZE_TWO: begin
                    st_nxt.readData = st_r.haltFreezeControlTwo & MASK_FREEZE_TWO; // [R14]
                end
                default: begin
                    st_nxt.readData = RST_READ_DATA;
                end
            endcase
        end
        // System reset only touches the answer register [R1]
        if (!rst_b) begin
            st_nxt.readData = RST_READ_DATA;
        end
    end

    // Asynchronous power-on clear, constants only [R1] [R3]
    always_ff @(posedge ref_clk or negedge porRst_b) begin
        if (!porRst_b) begin
            st_r <= RST_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdData = st_r.readData;

    // Freeze bits in the same order as the gate struct
    assign freezeVec = {
        st_r.haltFreezeControlOne[POS_LOW_POWER_TIMER], // [R4]
        st_r.haltFreezeControlOne[POS_INDEP_WATCHDOG],  // [R5]
        st_r.haltFreezeControlOne[POS_WINDOW_WATCHDOG], // [R6]
        st_r.haltFreezeControlOne[POS_CALENDAR_CLOCK],  // [R7]
        st_r.haltFreezeControlOne[POS_TIMER_3],         // [R8]
        st_r.haltFreezeControlTwo[POS_TIMER_17],        // [R9]
        st_r.haltFreezeControlTwo[POS_TIMER_16],        // [R10]
        st_r.haltFreezeControlTwo[POS_TIMER_14],        // [R11]
        st_r.haltFreezeControlTwo[POS_ADVANCED_TIMER]   // [R12]
    };

    // Combinational so the gate follows halt in the same cycle
    for (genvar g = 0; g < GATE_N; g++) begin : gGate
        assign enableVec[g] = !(coreHalted && freezeVec[g]); // [R15]
    end

    assign clkEnable = dcf_gate_t'(enableVec);

    // Helper: last cycle carried a read of a given offset
    logic        prevRd;
    logic [7:0]  prevAddr;
    logic [31:0] prevOne;
    logic [31:0] prevTwo;
    // Cleared with the bank, else a mid-run power-on clear looks like a stray change
    always_ff @(posedge ref_clk or negedge porRst_b) begin
        if (!porRst_b) begin
            prevRd   <= 1'b0;
            prevAddr <= 8'h00;
            prevOne  <= RST_FREEZE_ONE;
            prevTwo  <= RST_FREEZE_TWO;
        end else begin
            prevRd   <= busReq.rdStb;
            prevAddr <= busReq.addr;
            prevOne  <= st_r.haltFreezeControlOne;
            prevTwo  <= st_r.haltFreezeControlTwo;
        end
    end

    sequence sWriteOne;
        busReq.wrStb && busReq.addr == OFS_FREEZE_ONE;
    endsequence

    sequence sWriteTwo;
        busReq.wrStb && busReq.addr == OFS_FREEZE_TWO;
    endsequence

    AST_POR_CLEARS: assert property ( // [R3]
        @(posedge ref_clk) $rose(porRst_b) |-> st_r.haltFreezeControlOne == RST_FREEZE_ONE
            && st_r.haltFreezeControlTwo == RST_FREEZE_TWO)
        else $error("Freeze registers not clear after power-on");

    AST_SYSRST_KEEPS: assert property ( // [R1]
        @(posedge ref_clk) disable iff (!porRst_b)
        (!rst_b && !busReq.wrStb) |=> st_r.haltFreezeControlOne == $past(st_r.haltFreezeControlOne)
            && st_r.haltFreezeControlTwo == $past(st_r.haltFreezeControlTwo))
        else $error("System reset disturbed freeze registers");

    AST_WRITE_IN_RESET: assert property ( // [R2]
        @(posedge ref_clk) disable iff (!porRst_b)
        (!rst_b and sWriteOne) |=> st_r.haltFreezeControlOne == ($past(busReq.wrData)
            & MASK_FREEZE_ONE))
        else $error("Write lost under system reset");

    AST_WRITE_THEN_READ_ONE: assert property ( // [R14]
        @(posedge ref_clk) disable iff (!porRst_b || !rst_b)
        (sWriteOne ##1 (busReq.rdStb && busReq.addr == OFS_FREEZE_ONE && !busReq.wrStb))
            |=> rdData == ($past(busReq.wrData, 2) & MASK_FREEZE_ONE))
        else $error("Register one readback mismatch");

    AST_WRITE_THEN_READ_TWO: assert property ( // [R14]
        @(posedge ref_clk) disable iff (!porRst_b || !rst_b)
        (sWriteTwo ##1 (busReq.rdStb && busReq.addr == OFS_FREEZE_TWO && !busReq.wrStb))
            |=> rdData == ($past(busReq.wrData, 2) & MASK_FREEZE_TWO))
        else $error("Register two readback mismatch");

    AST_RESERVED_ZERO: assert property ( // [R14]
        @(posedge ref_clk) disable iff (!porRst_b)
        (st_r.haltFreezeControlOne & ~MASK_FREEZE_ONE) == 32'h0000_0000
            && (st_r.haltFreezeControlTwo & ~MASK_FREEZE_TWO) == 32'h0000_0000)
        else $error("Reserved freeze bit set");

    AST_READ_IDLE_ZERO: assert property (
        @(posedge ref_clk) disable iff (!porRst_b)
        !$past(busReq.rdStb) |-> rdData == 32'h0000_0000)
        else $error("Read data not zero outside answer cycle");

    AST_UNMAPPED_ZERO: assert property (
        @(posedge ref_clk) disable iff (!porRst_b)
        (prevRd && prevAddr != OFS_FREEZE_ONE && prevAddr != OFS_FREEZE_TWO)
            |-> rdData == 32'h0000_0000)
        else $error("Unmapped read returned data");

    AST_LPTIMER_GATE: assert property ( // [R4]
        @(posedge ref_clk) disable iff (!porRst_b)
        clkEnable.lowPowerTimer == !(coreHalted && st_r.haltFreezeControlOne[31]))
        else $error("Low-power timer gate wrong");

    AST_WATCHDOG_GATES: assert property ( // [R5] [R6]
        @(posedge ref_clk) disable iff (!porRst_b)
        coreHalted |-> clkEnable.independentWatchdog == !st_r.haltFreezeControlOne[12]
            && clkEnable.windowWatchdog == !st_r.haltFreezeControlOne[11])
        else $error("Watchdog gate wrong");

    AST_CAL_T3_GATES: assert property ( // [R7] [R8]
        @(posedge ref_clk) disable iff (!porRst_b)
        coreHalted |-> clkEnable.calendarClock == !st_r.haltFreezeControlOne[10]
            && clkEnable.generalTimerThree == !st_r.haltFreezeControlOne[1])
        else $error("Calendar or timer three gate wrong");

    AST_REG_TWO_GATES: assert property ( // [R9] [R10] [R11] [R12]
        @(posedge ref_clk) disable iff (!porRst_b)
        coreHalted |-> {clkEnable.generalTimerSeventeen, clkEnable.generalTimerSixteen,
            clkEnable.generalTimerFourteen, clkEnable.advancedTimerOne}
            == ~{st_r.haltFreezeControlTwo[18], st_r.haltFreezeControlTwo[17],
            st_r.haltFreezeControlTwo[15], st_r.haltFreezeControlTwo[11]})
        else $error("Register two gate wrong");

    AST_RUN_WHEN_NOT_HALTED: assert property ( // [R15]
        @(posedge ref_clk) disable iff (!porRst_b)
        $fell(coreHalted) |-> clkEnable == dcf_gate_t'({GATE_N{1'b1}}))
        else $error("Gate did not reopen after halt");

    AST_HOLD_NO_WRITE: assert property (
        @(posedge ref_clk) disable iff (!porRst_b)
        !$past(busReq.wrStb) |-> st_r.haltFreezeControlOne == prevOne
            && st_r.haltFreezeControlTwo == prevTwo)
        else $error("Freeze register changed without write");

    AST_WRITE_TWO_IN_RESET: assert property ( // [R2]
        @(posedge ref_clk) disable iff (!porRst_b)
        (!rst_b and sWriteTwo) |=> st_r.haltFreezeControlTwo == ($past(busReq.wrData)
            & MASK_FREEZE_TWO))
        else $error("Register two write lost under system reset");

    AST_SYSRST_READ_ZERO: assert property ( // [R1]
        @(posedge ref_clk) disable iff (!porRst_b)
        !rst_b |=> rdData == 32'h0000_0000)
        else $error("Read data not cleared by system reset");

    AST_LPTIMER_BIT_KEPT: assert property ( // [R4]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteOne |=> st_r.haltFreezeControlOne[POS_LOW_POWER_TIMER]
            == $past(busReq.wrData[POS_LOW_POWER_TIMER]))
        else $error("Low-power timer freeze bit not stored");

    AST_INDEP_DOG_BIT_KEPT: assert property ( // [R5]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteOne |=> st_r.haltFreezeControlOne[POS_INDEP_WATCHDOG]
            == $past(busReq.wrData[POS_INDEP_WATCHDOG]))
        else $error("Independent watchdog freeze bit not stored");

    AST_WINDOW_DOG_BIT_KEPT: assert property ( // [R6]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteOne |=> st_r.haltFreezeControlOne[POS_WINDOW_WATCHDOG]
            == $past(busReq.wrData[POS_WINDOW_WATCHDOG]))
        else $error("Window watchdog freeze bit not stored");

    AST_CALENDAR_BIT_KEPT: assert property ( // [R7]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteOne |=> st_r.haltFreezeControlOne[POS_CALENDAR_CLOCK]
            == $past(busReq.wrData[POS_CALENDAR_CLOCK]))
        else $error("Calendar freeze bit not stored");

    AST_TIMER_THREE_BIT_KEPT: assert property ( // [R8]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteOne |=> st_r.haltFreezeControlOne[POS_TIMER_3]
            == $past(busReq.wrData[POS_TIMER_3]))
        else $error("Timer three freeze bit not stored");

    AST_TIMER_SEVENTEEN_BIT_KEPT: assert property ( // [R9]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteTwo |=> st_r.haltFreezeControlTwo[POS_TIMER_17]
            == $past(busReq.wrData[POS_TIMER_17]))
        else $error("Timer seventeen freeze bit not stored");

    AST_TIMER_SIXTEEN_BIT_KEPT: assert property ( // [R10]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteTwo |=> st_r.haltFreezeControlTwo[POS_TIMER_16]
            == $past(busReq.wrData[POS_TIMER_16]))
        else $error("Timer sixteen freeze bit not stored");

    AST_TIMER_FOURTEEN_BIT_KEPT: assert property ( // [R11]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteTwo |=> st_r.haltFreezeControlTwo[POS_TIMER_14]
            == $past(busReq.wrData[POS_TIMER_14]))
        else $error("Timer fourteen freeze bit not stored");

    AST_ADVANCED_BIT_KEPT: assert property ( // [R12]
        @(posedge ref_clk) disable iff (!porRst_b)
        sWriteTwo |=> st_r.haltFreezeControlTwo[POS_ADVANCED_TIMER]
            == $past(busReq.wrData[POS_ADVANCED_TIMER]))
        else $error("Advanced timer freeze bit not stored");

    AST_RUN_WHEN_RUNNING: assert property ( // [R15]
        @(posedge ref_clk) disable iff (!porRst_b)
        !coreHalted |-> clkEnable == dcf_gate_t'({GATE_N{1'b1}}))
        else $error("Gate closed while core running");

    AST_CLOSED_ONLY_HALTED: assert property ( // [R15]
        @(posedge ref_clk) disable iff (!porRst_b)
        clkEnable != dcf_gate_t'({GATE_N{1'b1}}) |-> coreHalted)
        else $error("Gate closed without halt");

    AST_READ_ONE_VALUE: assert property ( // [R14]
        @(posedge ref_clk) disable iff (!porRst_b)
        (busReq.rdStb && busReq.addr == OFS_FREEZE_ONE && rst_b)
            |=> rdData == $past(st_r.haltFreezeControlOne))
        else $error("Register one read value wrong");

    AST_READ_TWO_VALUE: assert property ( // [R14]
        @(posedge ref_clk) disable iff (!porRst_b)
        (busReq.rdStb && busReq.addr == OFS_FREEZE_TWO && rst_b)
            |=> rdData == $past(st_r.haltFreezeControlTwo))
        else $error("Register two read value wrong");

    AST_RESERVED_READ_ZERO: assert property ( // [R14]
        @(posedge ref_clk) disable iff (!porRst_b)
        prevRd |-> (rdData & ~(MASK_FREEZE_ONE | MASK_FREEZE_TWO)) == 32'h0000_0000)
        else $error("Reserved bit read as one");

endmodule

// ### test/dcf_halt_model.sv
// Purpose: Core halt source and gated peripheral counters around the freeze bank
// Assumes: Halt request from the bench is taken on the rising clock edge
// Notes:   Counters tick only on cycles whose gate is open, like a gated clock
module dcf_halt_model
    import dcf_pkg::*;
(
    // Clock and power-on reset
    input  wire logic             ref_clk,
    input  wire logic             porRst_b,
    // Bench control
    input  wire logic             haltReq,
    // Gate link
    input  wire dcf_gate_t        clkEnable,
    output logic                  coreHalted,
    output logic [8:0][15:0]      ticks
);
    timeunit 1ns;
    timeprecision 1ps;

    // Halt has no reset of its own so a power-on pulse can land mid-halt
    always_ff @(posedge ref_clk) begin
        coreHalted <= haltReq;
    end

    always_ff @(posedge ref_clk or negedge porRst_b) begin
        if (!porRst_b) begin
            ticks <= '0;
        end else begin
            for (int i = 0; i < 9; i++) begin
                ticks[i] <= ticks[i] + 16'(clkEnable[i]);
            end
        end
    end
endmodule

// ### test/debug_counter_freeze_control_bench.sv
// Purpose: Self-checking bench for the debug freeze bank
// Assumes: Full word accesses only, one strobe per request
// Notes:   Random stimulus from a fixed seed plus corner words
module debug_counter_freeze_control_bench;
    import dcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic             ref_clk, rst_b, porRst_b, haltReq, coreHalted;
    dcf_req_t         busReq;
    logic [31:0]      rdData, got, one, two, w1, w2;
    dcf_gate_t        clkEnable;
    logic [8:0][15:0] ticks, t0;
    logic [7:0]       ua;
    int               n_errors, n_tests, seed;

    dcf_freeze_bank u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .porRst_b(porRst_b),
        .busReq(busReq), .rdData(rdData), .coreHalted(coreHalted), .clkEnable(clkEnable));
    dcf_halt_model u_model (.ref_clk(ref_clk), .porRst_b(porRst_b), .haltReq(haltReq),
        .clkEnable(clkEnable), .coreHalted(coreHalted), .ticks(ticks));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Word writes only, never narrower
    task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
        @(posedge ref_clk);
        busReq <= '0;
    endtask

    task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        busReq <= '{addr: a, wrData: 32'h0000_0000, wrStb: 1'b0, rdStb: 1'b1};
        @(posedge ref_clk);
        busReq <= '0;
        #1 d = rdData;
    endtask

    function automatic logic [8:0] expGate(logic h, logic [31:0] a, logic [31:0] b);
        return ~({a[31], a[12], a[11], a[10], a[1], b[18], b[17], b[15], b[11]} & {9{h}});
    endfunction

    task automatic checkRegs(input logic h);
        rdReg(8'h08, got);
        check("freeze one", got, one);
        rdReg(8'h0c, got);
        check("freeze two", got, two);
        check("gates", 32'(clkEnable), 32'(expGate(h, one, two)));
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end

    initial begin
        seed = 32'h2cec5a88;
        {rst_b, porRst_b, haltReq, busReq, n_errors, n_tests} = '0;
        repeat (8) @(posedge ref_clk);
        {rst_b, porRst_b} <= 2'b11;
        {one, two} = '0;
        haltReq <= 1'b1;
        checkRegs(1'b1);
        for (int k = 0; k < 40; k++) begin
            w1 = (k == 0) ? 32'hffff_ffff : $random(seed);
            w2 = (k == 0) ? 32'hffff_ffff : $random(seed);
            wrReg(8'h08, w1);
            wrReg(8'h0c, w2);
            ua = 8'($random(seed));
            ua = (ua == 8'h08 || ua == 8'h0c) ? ua ^ 8'h01 : ua;
            wrReg(ua, 32'($random(seed)));
            rdReg(ua, got);
            check("unmapped read", got, 32'h0000_0000);
            one = w1 & 32'h8000_1c02;
            two = w2 & 32'h0006_8800;
            haltReq <= (k == 0) ? 1'b1 : 1'($random(seed));
            repeat (2) @(posedge ref_clk);
            checkRegs(haltReq);
        end
        // Write then read with no gap, both registers
        for (int r = 0; r < 2; r++) begin
            ua = r ? 8'h0c : 8'h08;
            @(posedge ref_clk);
            busReq <= '{addr: ua, wrData: w1, wrStb: 1'b1, rdStb: 1'b0};
            @(posedge ref_clk);
            busReq <= '{addr: ua, wrData: 32'h0000_0000, wrStb: 1'b0, rdStb: 1'b1};
            @(posedge ref_clk);
            busReq <= '0;
            #1 check("back to back", rdData, w1 & (r ? 32'h0006_8800 : 32'h8000_1c02));
        end
        // Only the independent watchdog frozen; halted, then released
        wrReg(8'h08, 32'h0000_1000);
        wrReg(8'h0c, 32'h0000_0000);
        for (int h = 1; h >= 0; h--) begin
            @(posedge ref_clk);
            haltReq <= 1'(h);
            repeat (3) @(posedge ref_clk);
            #1 t0 = ticks;
            repeat (10) @(posedge ref_clk);
            #1 check("watchdog ticks", 32'(ticks[7] - t0[7]), h ? 32'h0 : 32'ha);
            check("timer one ticks", 32'(ticks[0] - t0[0]), 32'h0000_000a);
        end
        // System reset still takes writes and answers reads with zero
        rst_b <= 1'b0;
        wrReg(8'h08, 32'h8000_0002);
        wrReg(8'h0c, 32'h0006_0000);
        rdReg(8'h08, got);
        check("read under reset", got, 32'h0000_0000);
        rst_b <= 1'b1;
        {one, two} = {32'h8000_0002, 32'h0006_0000};
        haltReq <= 1'b1;
        repeat (2) @(posedge ref_clk);
        checkRegs(1'b1);
        // Power-on reset off the edge must clear at once
        #1 porRst_b = 1'b0;
        #1 check("gates under power-on", 32'(clkEnable), 32'h0000_01ff);
        @(posedge ref_clk);
        porRst_b <= 1'b1;
        {one, two} = '0;
        checkRegs(1'b1);
        complete_run();
    end
endmodule
